/* File: hw/i2s_defs.svh */
// Constants of the two-wire slave: address ranges, counts, reset values
`ifndef I2S_DEFS_SVH
`define I2S_DEFS_SVH

// Seven-bit address space classes
`define I2S_V7_LO    7'h08
`define I2S_V7_HI    7'h77
`define I2S_H10_LO   7'h78
`define I2S_H10_HI   7'h7b
`define I2S_RSV_LO   7'h7c

// Ten-bit header literal in the first address byte
`define I2S_HDR10    5'h1e

// Bit counts within one byte frame
`define I2S_LAST_BIT 4'h7
`define I2S_BITS     4'h8
`define I2S_ACK_BIT  4'h9

// Reset value of the clock release bit
`define I2S_REL_RST  1'h1

// Reset level of the pin synchronisers: bus released
`define I2S_PIN_RST  3'h7

`endif

/* File: hw/i2s_pkg.sv */
// Types of the two-wire slave
package i2s_pkg;

    // Protocol phase
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADR1 = 3'b001,
        S_ADR2 = 3'b010,
        S_RX   = 3'b011,
        S_TX   = 3'b100
    } i2s_fsm_t;

    // Static configuration from software
    typedef struct packed {
        logic       module_enable;
        logic       stretch_enable;
        logic       ten_bit_addr_sel;
        logic [9:0] own_address_reg;
    } i2s_cfg_t;

    // Software strobes, one cycle each
    typedef struct packed {
        logic       tx_wr;
        logic [7:0] tx_data;
        logic       rx_rd;
        logic       rel_set;
        logic       rel_clr;
        logic       ov_clr;
    } i2s_cmd_t;

    // Status seen by software
    typedef struct packed {
        logic [7:0] rx_buffer;
        logic       rx_full_flag;
        logic       rx_overflow_flag;
        logic       tx_full_flag;
        logic       clock_release_bit;
        logic       full_match_flag;
        logic       addressed_state;
        logic       read_dir;
    } i2s_stat_t;

    // Whole state of the slave
    typedef struct packed {
        i2s_fsm_t   fsm;
        i2s_fsm_t   nxt;
        logic [3:0] cnt;
        logic [7:0] rx_shift_reg;
        logic [7:0] tx_shift;
        logic       go;
        logic       sda_low;
        logic       hold;
        logic       clr_pend;
        logic       rel;
        logic [7:0] rxbuf;
        logic       rxf;
        logic       ov;
        logic       txf;
        logic [7:0] txr;
        logic       tx_act;
        logic       fm;
        logic       adr;
        logic       rdd;
        logic       mack;
        logic       ev;
        logic       scl_s1;
        logic       scl_s2;
        logic       scl_d;
        logic       sda_s1;
        logic       sda_s2;
        logic       sda_d;
        logic       bit_s1;
        logic       bit_s2;
    } i2s_state_t;

endpackage

/* File: hw/i2s_slave.sv */
// Two-wire bus slave with address match, double-buffered receive, stretch
`timescale 1ns/10ps
`include "i2s_defs.svh"

module i2s_slave
    import i2s_pkg::*;
(
    // Clocks, reset, enable
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      ce_i,
    // Link pins
    input  wire logic      scl_i,
    output logic           scl_o,
    output logic           scl_oe_o,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe_o,
    // Software side
    input  wire i2s_cfg_t  cfg_i,
    input  wire i2s_cmd_t  cmd_i,
    output i2s_stat_t      stat_o,
    output logic           slave_event_flag_o,
    output logic           master_event_flag_o
);

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------

    // Data bit caught on the rising SCL edge
    logic link_bit;

    always_ff @(posedge scl_i)
    begin
        link_bit <= sda_i;
    end

    // ------------------------------------------------------------
    // Main state
    // ------------------------------------------------------------

    i2s_state_t s;
    i2s_state_t next_s;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] nb;

    // Seven-bit own address lies in the usable range
    function automatic logic valid7(input logic [6:0] a);
        valid7 = (a >= `I2S_V7_LO) && (a <= `I2S_V7_HI);
    endfunction

    // Bus edge and condition detection on synchronised pins
    always_comb
    begin
        rise  = s.scl_s2 & ~s.scl_d;
        fall  = ~s.scl_s2 & s.scl_d;
        start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
        stop  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
        nb    = {s.rx_shift_reg[6:0], s.bit_s2};
    end

    // Next state
    always_comb
    begin
        next_s = s;
        next_s.ev = 1'b0;

        // Synchronisers
        next_s.scl_s1 = scl_i;
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_d  = s.scl_s2;
        next_s.sda_s1 = sda_i;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_d  = s.sda_s2;
        next_s.bit_s1 = link_bit;
        next_s.bit_s2 = s.bit_s1;

        // Software strobes
        if (cmd_i.rx_rd)
            next_s.rxf = 1'b0;
        if (cmd_i.ov_clr)
            next_s.ov = 1'b0;
        if (cmd_i.tx_wr)
        begin
            next_s.txr = cmd_i.tx_data;
            next_s.txf = 1'b1;
        end
        if (cmd_i.rel_set)
        begin
            next_s.rel      = 1'b1;
            next_s.hold     = 1'b0;
            next_s.clr_pend = 1'b0;
        end
        else if (cmd_i.rel_clr && cfg_i.stretch_enable)
        begin
            next_s.rel      = 1'b0;
            next_s.clr_pend = 1'b1;
        end

        // Software clear takes hold only after a falling edge
        if (s.clr_pend && fall && !cmd_i.rel_set)
        begin
            next_s.hold     = 1'b1;
            next_s.clr_pend = 1'b0;
        end

        if (!cfg_i.module_enable)
        begin
            next_s.fsm     = S_IDLE;
            next_s.sda_low = 1'b0;
            next_s.hold    = 1'b0;
            next_s.adr     = 1'b0;
        end
        else if (stop)
        begin
            next_s.fsm     = S_IDLE;
            next_s.sda_low = 1'b0;
            next_s.adr     = 1'b0;
            next_s.tx_act  = 1'b0;
        end
        else if (start)
        begin
            next_s.fsm     = S_ADR1;
            next_s.cnt     = 4'h0;
            next_s.sda_low = 1'b0;
            next_s.tx_act  = 1'b0;
        end
        else
        begin
            unique case (s.fsm)
                S_IDLE:
                begin
                    next_s.cnt = 4'h0;
                end

                // Receiving bytes: addresses and data
                S_ADR1, S_ADR2, S_RX:
                begin
                    if (rise && s.cnt < `I2S_BITS)
                    begin
                        next_s.rx_shift_reg = nb;
                        next_s.cnt = s.cnt + 4'h1;
                    end
                    if (rise && s.cnt == `I2S_LAST_BIT)
                    begin
                        next_s.nxt = S_IDLE;
                        next_s.go  = 1'b0;
                        if (s.fsm == S_ADR1 && cfg_i.ten_bit_addr_sel)
                        begin
                            next_s.fm = 1'b0;
                            if (nb[7:3] == `I2S_HDR10 &&
                                nb[2:1] == cfg_i.own_address_reg[9:8])
                            begin
                                if (!nb[0])
                                begin
                                    next_s.go  = 1'b1;
                                    next_s.nxt = S_ADR2;
                                end
                                else if (s.adr)
                                begin
                                    next_s.go  = 1'b1;
                                    next_s.nxt = S_TX;
                                    next_s.rdd = 1'b1;
                                end
                            end
                            if (!(next_s.go))
                                next_s.adr = 1'b0;
                        end
                        else if (s.fsm == S_ADR1)
                        begin
                            next_s.adr = 1'b0;
                            if (nb[7:1] == cfg_i.own_address_reg[6:0] &&
                                valid7(cfg_i.own_address_reg[6:0]))
                            begin
                                next_s.go  = 1'b1;
                                next_s.adr = 1'b1;
                                next_s.rdd = nb[0];
                                next_s.nxt = nb[0] ? S_TX : S_RX;
                            end
                        end
                        else if (s.fsm == S_ADR2)
                        begin
                            next_s.fm  = (nb == cfg_i.own_address_reg[7:0]);
                            next_s.adr = next_s.fm;
                            next_s.go  = next_s.fm;
                            next_s.rdd = 1'b0;
                            next_s.nxt = next_s.fm ? S_RX : S_IDLE;
                        end
                        else
                        begin
                            // Data byte: buffer full wins over overflow
                            next_s.nxt = S_RX;
                            next_s.go  = !s.rxf && !s.ov;
                            if (s.rxf)
                                next_s.ov = 1'b1;
                            else
                            begin
                                next_s.rxbuf = nb;
                                next_s.rxf   = 1'b1;
                            end
                        end
                    end
                    // Ninth clock low phase: acknowledge drive
                    if (fall && s.cnt == `I2S_BITS)
                    begin
                        next_s.sda_low = s.go;
                        next_s.cnt     = `I2S_ACK_BIT;
                    end
                    // End of ninth clock: event, stretch, next phase
                    if (fall && s.cnt == `I2S_ACK_BIT)
                    begin
                        next_s.sda_low = 1'b0;
                        next_s.cnt     = 4'h0;
                        next_s.fsm     = s.nxt;
                        next_s.ev      = s.go || (s.fsm == S_RX);
                        if (s.go && s.nxt == S_TX && !s.txf)
                        begin
                            next_s.rel  = 1'b0;
                            next_s.hold = 1'b1;
                        end
                        else if (s.go && s.fsm != S_RX && cfg_i.stretch_enable &&
                                 cfg_i.ten_bit_addr_sel && s.nxt != S_TX)
                        begin
                            next_s.rel  = 1'b0;
                            next_s.hold = 1'b1;
                        end
                        else if (s.fsm == S_RX && cfg_i.stretch_enable &&
                                 s.rxf && !cmd_i.rx_rd)
                        begin
                            next_s.rel  = 1'b0;
                            next_s.hold = 1'b1;
                        end
                    end
                end

                // Transmitting a data byte
                S_TX:
                begin
                    if (!s.tx_act && s.cnt == 4'h0 && s.txf && s.rel)
                    begin
                        next_s.tx_shift = s.txr;
                        next_s.txf      = cmd_i.tx_wr;
                        next_s.tx_act   = 1'b1;
                        next_s.sda_low  = ~s.txr[7];
                    end
                    if (s.tx_act && rise && s.cnt < `I2S_ACK_BIT)
                    begin
                        next_s.cnt = s.cnt + 4'h1;
                        if (s.cnt == `I2S_BITS)
                            next_s.mack = s.bit_s2;
                    end
                    if (s.tx_act && fall)
                    begin
                        if (s.cnt != 4'h0 && s.cnt < `I2S_BITS)
                        begin
                            next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
                            next_s.sda_low  = ~s.tx_shift[6];
                        end
                        else if (s.cnt == `I2S_BITS)
                            next_s.sda_low = 1'b0;
                        else if (s.cnt == `I2S_ACK_BIT)
                        begin
                            next_s.ev     = 1'b1;
                            next_s.cnt    = 4'h0;
                            next_s.tx_act = 1'b0;
                            if (s.mack)
                            begin
                                next_s.fsm = S_IDLE;
                                next_s.rdd = 1'b0;
                            end
                            else if (!s.txf)
                            begin
                                next_s.rel  = 1'b0;
                                next_s.hold = 1'b1;
                            end
                        end
                    end
                end

                default:
                begin
                    next_s.fsm = S_IDLE;
                end
            endcase
        end
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s     <= '0;
            s.rel <= `I2S_REL_RST;
            // Synchronisers start at the idle pin level, no false edge
            {s.scl_s1, s.scl_s2, s.scl_d} <= `I2S_PIN_RST;
            {s.sda_s1, s.sda_s2, s.sda_d} <= `I2S_PIN_RST;
        end
        else if (ce_i)
            s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Open-drain pins: only pull low or release
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = s.hold;
    assign sda_oe_o = s.sda_low;

    // Event flags; master side is not built here
    assign slave_event_flag_o  = s.ev;
    assign master_event_flag_o = 1'b0;

    // Status to software
    assign stat_o = '{rx_buffer:         s.rxbuf,
                      rx_full_flag:      s.rxf,
                      rx_overflow_flag:  s.ov,
                      tx_full_flag:      s.txf,
                      clock_release_bit: s.rel,
                      full_match_flag:   s.fm,
                      addressed_state:   s.adr,
                      read_dir:          s.rdd};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence rx_byte_done;
        ce_i && cfg_i.module_enable && !start && !stop &&
        s.fsm == S_RX && rise && s.cnt == `I2S_LAST_BIT;
    endsequence

    sequence ninth_fall_tx;
        ce_i && cfg_i.module_enable && !start && !stop && s.fsm == S_TX &&
        s.tx_act && fall && s.cnt == `I2S_ACK_BIT;
    endsequence

    a_start_shift: assert property (
        ce_i && cfg_i.module_enable && start |=> s.fsm == S_ADR1 && s.cnt == 4'h0)
        else $error("start did not enter address phase");

    a_rx_load: assert property (
        rx_byte_done and (!s.rxf && !cmd_i.tx_wr) |=>
        s.rxf && s.rxbuf == $past(nb))
        else $error("free buffer not loaded");

    a_rx_full_keep: assert property (
        rx_byte_done and s.rxf |=> s.rxbuf == $past(s.rxbuf) && s.ov && !s.go)
        else $error("full buffer overwritten or acked");

    a_ov_nack: assert property (
        rx_byte_done and (s.ov && !s.rxf && !cmd_i.ov_clr) |=> !s.go && s.rxf)
        else $error("overflow byte acked or not loaded");

    a_ack_drive: assert property (
        ce_i && cfg_i.module_enable && !start && !stop && s.fsm != S_TX &&
        s.fsm != S_IDLE && fall && s.cnt == `I2S_BITS && s.go |=> sda_oe_o)
        else $error("acknowledge not driven");

    a_tx_event: assert property (
        ninth_fall_tx |=> slave_event_flag_o ##1 !slave_event_flag_o)
        else $error("transmit event not one pulse");

    a_tx_stretch: assert property (
        ninth_fall_tx and (!s.mack && !s.txf && !cmd_i.rel_set) |=>
        scl_oe_o && !stat_o.clock_release_bit)
        else $error("transmit stretch missing");

    a_rel_ignored: assert property (
        ce_i && !cfg_i.stretch_enable && cmd_i.rel_clr && s.rel &&
        s.fsm == S_IDLE |=> stat_o.clock_release_bit)
        else $error("release write not ignored");

    a_sw_sync: assert property (
        ce_i && cfg_i.stretch_enable && cmd_i.rel_clr && !cmd_i.rel_set &&
        s.fsm == S_IDLE && !s.hold && !s.clr_pend |=> !scl_oe_o)
        else $error("software clear pulled SCL early");

    a_open_drain: assert property (
        !scl_o && !sda_o)
        else $error("pin driven high");

endmodule // i2s_slave

/* File: tb/i2s_master_model.sv */
// Bus master model that drives the two-wire link for the slave bench
`timescale 1ns/10ps

module i2s_master_model
(
    // Link clock
    input  wire logic lclk_i,
    // Resolved wire levels
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Open-drain pulls, high pulls the wire low
    output logic      scl_low_o,
    output logic      sda_low_o
);
    // SCL half period in link ticks
    localparam int HALF = 8;

    // Both lines released, bus idle
    initial
    begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // Wait some link ticks
    task automatic tick(input int n);
        repeat (n) @(posedge lclk_i);
    endtask

    // Release SCL, then wait while a slave stretches it
    task automatic scl_up();
        scl_low_o <= 1'b0;
        @(posedge lclk_i);
        repeat (4000) if (scl_i !== 1'b1) @(posedge lclk_i);
    endtask

    // Start or repeated start, SCL left low
    task automatic start();
        sda_low_o <= 1'b0;
        tick(HALF);
        scl_up();
        tick(HALF);
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_low_o <= 1'b1;
    endtask

    // Stop, both lines left released
    task automatic stop();
        tick(2);
        sda_low_o <= 1'b1;
        tick(HALF);
        scl_up();
        tick(HALF);
        sda_low_o <= 1'b0;
        tick(HALF);
    endtask

    // One clock pulse; data moves well after the fall, sampled on the rise
    task automatic clock_bit(input logic drive, input logic b, output logic s);
        tick(2);
        sda_low_o <= drive & !b;
        tick(HALF - 2);
        scl_up();
        s = sda_i;
        tick(HALF);
        scl_low_o <= 1'b1;
    endtask

    // Byte out MSB first, returns the acknowledge level
    task automatic write_byte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, d[i], s);
        clock_bit(1'b0, 1'b0, nack);
    endtask

    // Byte in MSB first, then the given acknowledge level
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b0, 1'b0, s);
            d[i] = s;
        end
        clock_bit(1'b1, nack, s);
    endtask
endmodule // i2s_master_model

/* File: tb/tb_i2s_slave.sv */
// Self-checking bench of the two-wire slave against a bus master model
`timescale 1ns/10ps

module tb_i2s_slave
    import i2s_pkg::*;
;
    // Command flags: tx_wr, rx_rd, rel_set, rel_clr, ov_clr
    localparam logic [4:0] TXW = 5'h10;
    localparam logic [4:0] RD  = 5'h08;
    localparam logic [4:0] RS  = 5'h04;
    localparam logic [4:0] RC  = 5'h02;
    localparam logic [4:0] OVC = 5'h01;
    localparam int LIMIT = 60000;

    logic       clk_i, lclk, rst_i, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic       m_scl_low, m_sda_low, scl_w, sda_w, full, ov;
    logic       slave_event_flag_o, master_event_flag_o;
    i2s_cfg_t   cfg_i;
    i2s_cmd_t   cmd_i;
    i2s_stat_t  stat_o;
    logic [7:0] ev_cnt, xbuf;
    logic [6:0] tab [6] = '{7'h07, 7'h08, 7'h77, 7'h78, 7'h7c, 7'h00};
    int         n_mismatch, tests_run;
    int         cyc = 0;

    // Open-drain wires with pull-ups
    assign scl_w = !((scl_oe_o & !scl_o) | m_scl_low);
    assign sda_w = !((sda_oe_o & !sda_o) | m_sda_low);

    i2s_slave u_i2s_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .cfg_i(cfg_i), .cmd_i(cmd_i), .stat_o(stat_o),
        .slave_event_flag_o(slave_event_flag_o), .master_event_flag_o(master_event_flag_o));
    i2s_master_model u_i2s_master_model (.lclk_i(lclk), .scl_i(scl_w), .sda_i(sda_w),
        .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

    // System clock 25 ns, link clock 125 ns at an unrelated phase
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        lclk = 1'b0;
        #7;
        forever #62.5 lclk = ~lclk;
    end

    // Event pulse counter and hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (slave_event_flag_o === 1'b1)
            ev_cnt <= ev_cnt + 8'h01;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic addr_ok(input logic [6:0] a);
        return a >= 7'h08 && a <= 7'h77;
    endfunction

    function automatic logic [7:0] hdr10(input logic [9:0] a, input logic rd);
        return {5'h1e, a[9:8], rd};
    endfunction

    // One-cycle software strobe
    task automatic sw(input logic [4:0] f, input logic [7:0] d);
        @(posedge clk_i);
        cmd_i <= {f[4], d, f[3:0]};
        @(posedge clk_i);
        cmd_i <= '0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic set_cfg(input logic s, input logic t, input logic [9:0] own);
        @(posedge clk_i);
        cfg_i <= {1'b1, s, t, own};
        repeat (4) @(posedge clk_i);
    endtask

    // Byte to the slave, acknowledge level compared
    task automatic wr(input logic [7:0] d, input logic exp);
        logic n;
        u_i2s_master_model.write_byte(d, n);
        chk_bit("ack_level", exp, n);
    endtask

    // Data byte against the bench's own buffer and overflow model
    task automatic rx_byte(input logic [7:0] d);
        wr(d, full | ov);
        if (!full)
            xbuf = d;
        ov = ov | full;
        full = 1'b1;
        repeat (8) @(posedge clk_i);
        chk_byte("rx_buffer", xbuf, stat_o.rx_buffer);
        chk_bit("overflow", ov, stat_o.rx_overflow_flag);
    endtask

    task automatic expect_free();
        repeat (30) @(posedge clk_i);
        chk_bit("scl_free", 1'b0, scl_oe_o);
    endtask

    // SCL held and release cleared, then serviced and released
    task automatic expect_hold(input logic [4:0] f, input logic [7:0] d);
        repeat (30) @(posedge clk_i);
        chk_bit("scl_held", 1'b1, scl_oe_o);
        chk_bit("release", 1'b0, stat_o.clock_release_bit);
        sw(f, d);
        sw(RS, 8'h00);
        expect_free();
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        logic [6:0] a;
        logic [9:0] b;
        logic [7:0] d, t, e0;
        rst_i = 1'b1;
        cmd_i = '0;
        cfg_i = {1'b1, 1'b0, 1'b0, 10'h000};
        ev_cnt = 8'h00;
        full = 1'b0;
        ov = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(23239));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        a = 7'h08 + 7'($urandom % 112);
        set_cfg(1'b0, 1'b0, {3'h0, a});
        sw(RC, 8'h00);
        chk_bit("release", 1'b1, stat_o.clock_release_bit);
        e0 = ev_cnt;
        u_i2s_master_model.start();
        wr({a, 1'b0}, 1'b0);
        repeat (8) @(posedge clk_i);
        chk_bit("rx_full", 1'b0, stat_o.rx_full_flag);
        repeat (2) rx_byte(8'($urandom));
        sw(RD, 8'h00);
        full = 1'b0;
        rx_byte(8'($urandom));
        sw(RD | OVC, 8'h00);
        full = 1'b0;
        ov = 1'b0;
        rx_byte(8'($urandom));
        u_i2s_master_model.stop();
        chk_byte("events", e0 + 8'h05, ev_cnt);
        $display("Test seven-bit receive done");
        foreach (tab[i])
        begin
            set_cfg(1'b0, 1'b0, {3'h0, tab[i]});
            u_i2s_master_model.start();
            wr({tab[i], 1'b0}, !addr_ok(tab[i]));
            u_i2s_master_model.stop();
        end
        set_cfg(1'b0, 1'b0, {3'h0, a});
        u_i2s_master_model.start();
        wr({a ^ 7'h01, 1'b0}, 1'b1);
        u_i2s_master_model.stop();
        $display("Test address refusal done");
        t = 8'($urandom);
        u_i2s_master_model.start();
        wr({a, 1'b1}, 1'b0);
        expect_hold(TXW, t);
        u_i2s_master_model.read_byte(1'b0, d);
        chk_byte("tx_byte", t, d);
        expect_hold(TXW, ~t);
        sw(TXW, t);
        u_i2s_master_model.read_byte(1'b0, d);
        chk_byte("tx_byte", ~t, d);
        expect_free();
        e0 = ev_cnt;
        u_i2s_master_model.read_byte(1'b1, d);
        chk_byte("tx_byte", t, d);
        expect_free();
        chk_byte("events", e0 + 8'h01, ev_cnt);
        u_i2s_master_model.stop();
        $display("Test seven-bit transmit done");
        set_cfg(1'b1, 1'b0, {3'h0, a});
        sw(RD | RC, 8'h00);
        full = 1'b0;
        chk_bit("release", 1'b0, stat_o.clock_release_bit);
        chk_bit("scl_free", 1'b0, scl_oe_o);
        fork
            begin
                u_i2s_master_model.start();
                wr({a, 1'b0}, 1'b0);
            end
            begin
                repeat (2000) if (scl_oe_o !== 1'b1) @(posedge clk_i);
                chk_bit("scl_held", 1'b1, scl_oe_o);
                sw(RS, 8'h00);
            end
        join
        rx_byte(8'($urandom));
        expect_hold(RD, 8'h00);
        full = 1'b0;
        fork
            rx_byte(8'($urandom));
            begin
                repeat (2000) if (stat_o.rx_full_flag !== 1'b1) @(posedge clk_i);
                sw(RD, 8'h00);
            end
        join
        full = 1'b0;
        expect_free();
        u_i2s_master_model.stop();
        $display("Test receive stretch done");
        b = 10'($urandom);
        set_cfg(1'b1, 1'b1, b);
        e0 = ev_cnt;
        u_i2s_master_model.start();
        wr(hdr10(b, 1'b0), 1'b0);
        expect_hold(5'h00, 8'h00);
        chk_bit("full_match", 1'b0, stat_o.full_match_flag);
        wr(b[7:0], 1'b0);
        expect_hold(5'h00, 8'h00);
        chk_bit("full_match", 1'b1, stat_o.full_match_flag);
        chk_byte("events", e0 + 8'h02, ev_cnt);
        rx_byte(8'($urandom));
        expect_hold(RD, 8'h00);
        full = 1'b0;
        t = 8'($urandom);
        u_i2s_master_model.start();
        wr(hdr10(b, 1'b1), 1'b0);
        expect_hold(TXW, t);
        u_i2s_master_model.read_byte(1'b1, d);
        chk_byte("tx_byte", t, d);
        u_i2s_master_model.stop();
        u_i2s_master_model.start();
        wr(hdr10(b, 1'b1), 1'b1);
        u_i2s_master_model.start();
        wr(hdr10(b ^ 10'h100, 1'b0), 1'b1);
        u_i2s_master_model.start();
        wr(hdr10(b, 1'b0), 1'b0);
        expect_hold(5'h00, 8'h00);
        wr(~b[7:0], 1'b1);
        chk_bit("full_match", 1'b0, stat_o.full_match_flag);
        u_i2s_master_model.stop();
        chk_bit("master_event", 1'b0, master_event_flag_o);
        $display("Test ten-bit addressing done");
        tally_and_finish();
    end
endmodule // tb_i2s_slave
